// [design/sram_host_ctrl.sv]
/*
  Host-side controller for a 32K x 8 asynchronous SRAM: turns single read or
  write requests into chip select, write strobe and output drive sequences.
  Assumes one 25 MHz clock, an asynchronous active-low reset and a board
  wire that resolves the data bus from dataOut/dataOe and the memory.
*/
`include "sram_port_defs.svh"

module sram_host_ctrl
  import sram_port_pkg::*;
#(
  parameter int READ_WAIT  = `READ_WAIT_CYC,
  parameter int WRITE_LOW  = `WRITE_LOW_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Request side
  input  wire logic       reqValid,
  output logic            reqReady,
  input  wire sram_req_t  req,
  output logic            rdValid,
  output logic [7:0]      rdData,
  // Memory pins
  output sram_pins_t      pins,
  output logic [7:0]      dataOut,
  output logic            dataOe,
  input  wire logic [7:0] dataIn
);

  // Counter width; fits any wait the timing parameters sensibly ask for
  localparam int CW = 4;
  // Read data crosses two flops before use, so the read wait covers them too
  localparam int SYNC_STAGES = 2;

  // Sequencer state
  sram_state_t   stateReg,   stateNext;
  logic [CW-1:0] cntReg,     cntNext;

  // Pin drive state
  sram_pins_t    pinsReg,    pinsNext;
  logic [7:0]    dataOutReg, dataOutNext;
  logic          dataOeReg,  dataOeNext;

  // Read return state
  logic [7:0]    rdDataReg,  rdDataNext;
  logic          rdValidReg, rdValidNext;

  // Data bus synchroniser
  logic [7:0]    syncA,      syncB;

  // Events decoded once and shared by the groups
  logic          takeRead,   takeWrite;
  logic          cntDone;

  // Cycle count to down-counter load value
  function automatic logic [CW-1:0] cyc(input int n);
    return CW'(n - 1);
  endfunction

  // Pins of a released port: deselected, strobe and drive high, address kept
  function automatic sram_pins_t idlePins(input logic [14:0] addr);
    sram_pins_t p;
    p.chipSelectN  = 1'b1;
    p.writeStrobeN = 1'b1;
    p.outputDriveN = 1'b1;
    p.addr         = addr;
    return p;
  endfunction

  // The memory drives the bus without our clock, so dataIn is synchronised
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= 8'h00;
      syncB <= 8'h00;
    end else begin
      syncA <= dataIn;
      syncB <= syncA;
    end
  end

  assign reqReady  = (stateReg == ST_IDLE);
  assign takeRead  = reqValid && reqReady && !req.write;
  assign takeWrite = reqValid && reqReady && req.write;
  assign cntDone   = (cntReg == '0);

  // Sequencer: next state and wait count
  always_comb begin
    stateNext = stateReg;
    cntNext   = cntReg;
    unique case (stateReg)
      ST_IDLE: begin
        if (takeWrite) begin
          cntNext   = cyc(WRITE_LOW);
          stateNext = ST_WLOW;
        end else if (takeRead) begin
          // Access time first, then the synchroniser stages
          cntNext   = cyc(READ_WAIT + SYNC_STAGES - 1);
          stateNext = ST_READ;
        end
      end
      ST_READ: begin
        if (cntDone) begin
          stateNext = ST_RDONE;
        end else begin
          cntNext = cntReg - 1'b1;
        end
      end
      ST_RDONE: stateNext = ST_TURN;
      ST_WLOW: begin
        if (cntDone) begin
          stateNext = ST_WEND;
        end else begin
          cntNext = cntReg - 1'b1;
        end
      end
      ST_WEND:  stateNext = ST_IDLE;
      ST_TURN:  stateNext = ST_IDLE;
      default:  stateNext = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateReg <= ST_IDLE;
      cntReg   <= '0;
    end else begin
      stateReg <= stateNext;
      cntReg   <= cntNext;
    end
  end

  // Pin drive: select, strobe, output drive, address and write data
  always_comb begin
    pinsNext    = pinsReg;
    dataOutNext = dataOutReg;
    dataOeNext  = dataOeReg;
    unique case (stateReg)
      ST_IDLE: begin
        pinsNext = idlePins(pinsReg.addr);
        if (takeRead || takeWrite) begin
          // Address and select move on one edge, so the address is never late
          pinsNext.addr        = req.addr;
          pinsNext.chipSelectN = 1'b0;
        end
        if (takeWrite) begin
          // Output drive stays high, so the memory floats before we drive
          pinsNext.writeStrobeN = 1'b0;
          dataOutNext           = req.data;
          dataOeNext            = 1'b1;
        end
        if (takeRead) begin
          pinsNext.outputDriveN = 1'b0;
        end
      end
      ST_READ: begin
        // Strobe never falls while the memory may drive the bus
        pinsNext.writeStrobeN = 1'b1;
      end
      ST_RDONE: pinsNext = idlePins(pinsReg.addr);
      ST_TURN: begin
        // One idle cycle lets the memory float before a write may drive
        dataOeNext = 1'b0;
      end
      ST_WLOW: begin
        if (cntDone) begin
          // Strobe alone ends the write; select, address and data stay a cycle
          pinsNext.writeStrobeN = 1'b1;
        end
      end
      ST_WEND: begin
        pinsNext   = idlePins(pinsReg.addr);
        dataOeNext = 1'b0;
      end
      default: pinsNext = idlePins(pinsReg.addr);
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinsReg    <= '{chipSelectN: 1'b1, writeStrobeN: 1'b1, outputDriveN: 1'b1,
                      addr: 15'h0000};
      dataOutReg <= 8'h00;
      dataOeReg  <= 1'b0;
    end else begin
      pinsReg    <= pinsNext;
      dataOutReg <= dataOutNext;
      dataOeReg  <= dataOeNext;
    end
  end

  // Read return: one-cycle valid pulse, byte held until the next read
  always_comb begin
    rdDataNext  = rdDataReg;
    rdValidNext = 1'b0;
    if (stateReg == ST_RDONE) begin
      rdDataNext  = syncB;
      rdValidNext = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdDataReg  <= 8'h00;
      rdValidReg <= 1'b0;
    end else begin
      rdDataReg  <= rdDataNext;
      rdValidReg <= rdValidNext;
    end
  end

  assign pins    = pinsReg;
  assign dataOut = dataOutReg;
  assign dataOe  = dataOeReg;
  assign rdData  = rdDataReg;
  assign rdValid = rdValidReg;

endmodule // sram_host_ctrl

// [common/sram_port_defs.svh]
/*
  Timing constants for the host-side controller of a 32K x 8 asynchronous SRAM.
  Assumes a 25 MHz system clock; the read and write counts below derive from ns figures, TURN_CYC is a fixed 1.
*/
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

`define CLK_PERIOD_NS                     40
`define ADDRESS_ACCESS_DELAY_NS           12
`define ADDRESS_CHANGE_DATA_HOLD_NS       3
`define ADDRESS_SETUP_TO_WRITE_END_NS     9
`define ADDRESS_HOLD_AFTER_WRITE_END_NS   0
`define DATA_SETUP_TO_WRITE_END_NS        8
`define DATA_HOLD_AFTER_WRITE_END_NS      0
`define STROBE_LOW_TO_FLOAT_DELAY_NS      7
// Least times round up, never below one cycle
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS < 1 ? 1 : \
                    ((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC   `CYC_UP(`ADDRESS_ACCESS_DELAY_NS)
`define WRITE_LOW_CYC   `CYC_UP(`STROBE_LOW_TO_FLOAT_DELAY_NS + `DATA_SETUP_TO_WRITE_END_NS)
`define TURN_CYC        1

`endif

// [common/sram_port_pkg.sv]
/*
  Types shared by the SRAM host controller.
  Assumes sram_port_defs.svh supplies the timing counts.
*/
package sram_port_pkg;
  typedef struct packed {
    logic        write;
    logic [14:0] addr;
    logic [7:0]  data;
  } sram_req_t;

  typedef struct packed {
    logic       chipSelectN;
    logic       writeStrobeN;
    logic       outputDriveN;
    logic [14:0] addr;
  } sram_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_READ  = 3'h1,
    ST_RDONE = 3'h3,
    ST_WLOW  = 3'h5,
    ST_WEND  = 3'h4,
    ST_TURN  = 3'h2
  } sram_state_t;
endpackage

// [test/sram_async_model.sv]
/* Behavioural 32K x 8 asynchronous memory facing the host controller.
   Assumes the bench feeds busLevel back as the controller's dataIn. */
module sram_async_model
  import sram_port_pkg::*;
(
  // Controller side
  input  wire sram_pins_t pins,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe,
  // Resolved bus
  output logic [7:0]      busLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:32767];
  logic [7:0] lastLevel = 8'h00;
  logic [7:0] memOut;
  wire writeOn = !pins.chipSelectN && !pins.writeStrobeN;
  wire memDrive = !pins.chipSelectN && pins.writeStrobeN && !pins.outputDriveN;
  assign #12 memOut = mem[pins.addr];
  // Store when the first of the two controls rises
  always @(negedge writeOn) mem[pins.addr] = busLevel;
  // An undriven bus shows the inverse of its last level, never a stale copy
  always @* if (dataOe || memDrive) lastLevel = dataOe ? dataOut : memOut;
  assign busLevel = (dataOe || memDrive) ? (dataOe ? dataOut : memOut) : ~lastLevel;
endmodule // sram_async_model

// [test/sram_host_ctrl_asserts.sv]
/* Pin-sequence checks of the SRAM host controller.
   Bound to sram_host_ctrl with default timing parameters. */
module sram_host_ctrl_checker
  import sram_port_pkg::*;
(
  // Clock, reset and request side
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       reqValid,
  input wire logic       reqReady,
  input wire sram_req_t  req,
  input wire logic       rdValid,
  // Memory pins
  input wire sram_pins_t pins,
  input wire logic [7:0] dataOut,
  input wire logic       dataOe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_strobe_high: assert property (!pins.outputDriveN |-> pins.writeStrobeN)
    else $error("strobe low while reading");
  a_no_contention: assert property (dataOe |-> pins.outputDriveN)
    else $error("bus driven while memory may drive");
  a_write_selected: assert property ($fell(pins.writeStrobeN) |-> !pins.chipSelectN && dataOe)
    else $error("strobe fell without select or data");
  a_write_length: assert property ($fell(pins.writeStrobeN) |=> pins.writeStrobeN)
    else $error("strobe low time wrong");
  a_data_setup: assert property ($rose(pins.writeStrobeN) |-> $stable(dataOut) && dataOe)
    else $error("write data moved before write end");
  a_addr_hold: assert property ($rose(pins.writeStrobeN) |-> $stable(pins.addr) ##1 $stable(pins.addr))
    else $error("address moved around write end");
  a_addr_at_select: assert property (reqValid && reqReady |-> ##1 $fell(pins.chipSelectN) && pins.addr == $past(req.addr))
    else $error("address not valid at select");
  a_read_answer: assert property (reqValid && reqReady && !req.write |-> ##4 rdValid ##1 !rdValid)
    else $error("read answer pulse misplaced");
endmodule // sram_host_ctrl_checker
bind sram_host_ctrl sram_host_ctrl_checker i_chk (.clk(clk), .reset_n(reset_n), .reqValid(reqValid),
  .reqReady(reqReady), .req(req), .rdValid(rdValid), .pins(pins), .dataOut(dataOut),
  .dataOe(dataOe));

// [test/sram_host_ctrl_tb_top.sv]
/* Bench for the SRAM host controller with a behavioural memory on its pins.
   Assumes default timing parameters of the controller. */
module sram_host_ctrl_tb_top
  import sram_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reqValid = 1'b0;
  sram_req_t req = '0;
  logic reqReady, rdValid, dataOe;
  logic [7:0] rdData, dataOut, busLevel;
  sram_pins_t pins;
  int bad_count = 0;
  int checks = 0;
  always #20 clk = ~clk;
  sram_host_ctrl i_dut (.clk(clk), .reset_n(reset_n), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rdValid(rdValid), .rdData(rdData), .pins(pins), .dataOut(dataOut),
    .dataOe(dataOe), .dataIn(busLevel));
  sram_async_model i_mem (.pins(pins), .dataOut(dataOut), .dataOe(dataOe), .busLevel(busLevel));
  task automatic results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic compare(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic ran_out();
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    results();
  endtask
  // Waits while busy, so a request made early stays pending instead of lost
  task automatic issue(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int n;
    // An edge passes first, so reqValid never falls and rises in one step
    @(posedge clk) #2;
    req = '{wr, a, d};
    reqValid = 1'b1;
    for (n = 0; !reqReady; n++) begin
      if (n > 20) ran_out();
      @(posedge clk) #2;
    end
    @(posedge clk) #2;
    reqValid = 1'b0;
    compare({7'h00, reqReady}, 8'h00);
    compare({7'h00, pins.chipSelectN}, 8'h00);
    compare(pins.addr[7:0], a[7:0]);
    compare({1'b0, pins.addr[14:8]}, {1'b0, a[14:8]});
    compare({7'h00, pins.writeStrobeN}, {7'h00, !wr});
    if (wr) begin
      compare(dataOut, d);
      compare({7'h00, dataOe}, 8'h01);
    end else begin
      compare({7'h00, pins.outputDriveN}, 8'h00);
      compare({7'h00, dataOe}, 8'h00);
    end
  endtask
  task automatic read_check(input logic [14:0] a, input logic [7:0] want);
    int n;
    issue(1'b0, a, 8'h00);
    for (n = 0; rdValid !== 1'b1; n++) begin
      if (n > 10) ran_out();
      @(posedge clk) #2;
    end
    compare(rdData, want);
    @(posedge clk) #2;
    compare({7'h00, rdValid}, 8'h00);
    compare(rdData, want);
  endtask
  task automatic boundary_bytes();
    issue(1'b1, 15'h0000, 8'ha5);
    issue(1'b1, 15'h7fff, 8'h3c);
    read_check(15'h0000, 8'ha5);
    read_check(15'h7fff, 8'h3c);
  endtask
  task automatic overwrite_turnaround();
    read_check(15'h7fff, 8'h3c);
    issue(1'b1, 15'h7fff, 8'hc3);
    read_check(15'h7fff, 8'hc3);
    read_check(15'h0000, 8'ha5);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #2 reset_n = 1'b1;
    boundary_bytes();
    overwrite_turnaround();
    results();
  end
endmodule // sram_host_ctrl_tb_top
